// file: csp_pkg.sv
// constants shared by both ends of the card socket power and index access link
package csp_pkg;
   // link widths
   localparam int unsigned DATA_W = 32;
   localparam int unsigned IDX_W = 8;
   localparam int unsigned FIFO_DEPTH = 4;
   // primary indices (socket b adds the socket bit to pwr, csc and csc_en only)
   localparam logic [7:0] IDX_PWR = 8'h02;
   localparam logic [7:0] IDX_CSC = 8'h04;
   localparam logic [7:0] IDX_CSC_EN = 8'h05;
   localparam logic [7:0] IDX_TSEL = 8'h06;
   localparam logic [7:0] IDX_EXT_INDEX = 8'h2e;
   localparam logic [7:0] IDX_EXT_DATA = 8'h2f;
   localparam logic [7:0] IDX_TIM0 = 8'h3a;
   localparam logic [7:0] IDX_TIM1 = 8'h3d;
   localparam int unsigned SOCK_BIT = 6;
   // extended indices
   localparam logic [7:0] EXT_CTL1 = 8'h03;
   localparam logic [7:0] EXT_PORT = 8'h0a;
   localparam logic [7:0] EXT_CTL2 = 8'h0b;
   // field positions
   localparam int unsigned PWR_VPP_LO = 0;
   localparam int unsigned PWR_AUTO_A = 4;
   localparam int unsigned PWR_AUTO_B = 5;
   localparam int unsigned PWR_VCC = 7;
   localparam int unsigned CSC_DET = 3;
   localparam int unsigned EXT1_AUTO_OFF = 1;
   localparam int unsigned EXT2_RD_EN = 3;
   localparam int unsigned EXT2_WR_EN = 4;
   localparam int unsigned TSEL_MEM = 0;
   localparam int unsigned TSEL_IO = 1;
   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_EXT1 = 8'h02;
   localparam logic [7:0] RST_TIM = 8'h01;
   // host apb map
   localparam logic [11:0] A_CMD = 12'h000;
   localparam logic [11:0] A_CTRL = 12'h004;
   localparam logic [11:0] A_STAT = 12'h008;
   localparam logic [11:0] A_RDATA = 12'h00c;
   localparam int unsigned C_GO = 0;
   localparam int unsigned C_WR = 1;
   localparam int unsigned C_ADDR = 2;
   localparam int unsigned C_SPACE = 3;
   localparam int unsigned C_SOCK = 4;
   localparam int unsigned C_WIN = 5;
   localparam int unsigned C_BE = 6;
endpackage : csp_pkg

// file: csp_link_if.sv
// link between host end and device end
`timescale 1ns/1ps
interface csp_link_if;
   logic req;
   logic wr;
   logic addr;
   logic space;
   logic sock;
   logic win;
   logic [1:0] be;
   logic [31:0] wdata;
   logic ready;
   logic [31:0] rdata;
   modport dev (input req, wr, addr, space, sock, win, be, wdata, output ready, rdata);
   modport hst (output req, wr, addr, space, sock, win, be, wdata, input ready, rdata);
endinterface : csp_link_if

// file: csp_wfifo.sv
// per-socket card write fifo with setup/command/recovery sequencer
`timescale 1ns/1ps
module csp_wfifo #(
   parameter int unsigned W = 32,
   parameter int unsigned DEPTH = 4
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // host side, msb of data is the timing set
   input wire logic i_push_valid,
   input wire logic [W:0] i_push_data,
   output logic o_push_ready,
   // timing of the head entry
   output logic o_head_set,
   input wire logic [7:0] i_setup,
   input wire logic [7:0] i_cmd,
   input wire logic [7:0] i_rec,
   // card side
   output logic o_empty,
   output logic o_card_cmd,
   output logic [W-1:0] o_card_data
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("csp_wfifo depth must be a power of two");
   end

   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_SETUP = 2'h1,
      PH_CMD = 2'h3,
      PH_REC = 2'h2
   } csp_ph_t;

   typedef struct packed {
      logic [DEPTH-1:0][W:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      csp_ph_t ph;
      logic [7:0] tmr;
      logic [W-1:0] data;
      logic cmd;
   } csp_fifo_st_t;

   csp_fifo_st_t s_q;
   csp_fifo_st_t s_d;
   logic push;
   logic pop;

   always_comb
   begin
      s_d = s_q;
      pop = 1'b0;
      o_push_ready = (s_q.cnt != FULL);
      push = i_push_valid & o_push_ready;
      case (s_q.ph)
         PH_IDLE:
         begin
            if (s_q.cnt != '0)
            begin
               s_d.data = s_q.mem[s_q.rp][W-1:0];
               s_d.tmr = i_setup;
               s_d.ph = PH_SETUP;
            end
         end
         PH_SETUP:
         begin
            if (s_q.tmr == 8'h00)
            begin
               s_d.tmr = i_cmd;
               s_d.cmd = 1'b1;
               s_d.ph = PH_CMD;
            end
            else
               s_d.tmr = s_q.tmr - 8'h01;
         end
         PH_CMD:
         begin
            if (s_q.tmr == 8'h00)
            begin
               s_d.tmr = i_rec;
               s_d.cmd = 1'b0;
               s_d.ph = PH_REC;
            end
            else
               s_d.tmr = s_q.tmr - 8'h01;
         end
         PH_REC:
         begin
            // entry freed only after recovery, so a full fifo really stalls
            if (s_q.tmr == 8'h00)
            begin
               pop = 1'b1;
               s_d.rp = s_q.rp + 1'b1;
               s_d.ph = PH_IDLE;
            end
            else
               s_d.tmr = s_q.tmr - 8'h01;
         end
         default:
            s_d.ph = PH_IDLE;
      endcase
      if (push)
      begin
         s_d.mem[s_q.wp] = i_push_data;
         s_d.wp = s_q.wp + 1'b1;
      end
      s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign o_head_set = s_q.mem[s_q.rp][W];
   assign o_empty = (s_q.cnt == '0);
   assign o_card_cmd = s_q.cmd;
   assign o_card_data = s_q.data;
endmodule : csp_wfifo

// file: csp_socket_dev.sv
// device end: socket power, management events, indexed registers, write fifos
`timescale 1ns/1ps
module csp_socket_dev #(
   parameter int unsigned DW = csp_pkg::DATA_W,
   parameter int unsigned DEPTH = csp_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // host link
   csp_link_if.dev link,
   // sockets, index 0 is socket a
   input wire logic [1:0] i_card_detect_first_n,
   input wire logic [1:0] i_card_detect_second_n,
   input wire logic [1:0] i_voltage_sense_strobe_one,
   input wire logic [1:0] i_voltage_sense_strobe_two,
   output logic [1:0] o_vcc_en,
   output logic [1:0] o_vpp_en,
   output logic [1:0] o_card_cmd,
   output logic [1:0][DW-1:0] o_card_data,
   output logic [1:0] o_fifo_empty,
   // management interrupt
   output logic o_mgmt_irq,
   // general-purpose ports
   input wire logic [7:0] i_gp_rd_data,
   output logic [7:0] o_gp_wr_data,
   output logic o_gp_wr_oe
);
   if (DW != 32)
   begin : g_bad_width
      $error("csp_socket_dev data width must be 32");
   end

   typedef struct packed {
      logic [7:0] idx;
      logic [7:0] ext_idx;
      logic [7:0] ext1;
      logic [7:0] ext2;
      logic [7:0] gp_wr;
      logic [7:0] gp_rd;
      logic [7:0] tsel;
      logic [5:0][7:0] tim;
      logic [1:0][7:0] pwr;
      logic [1:0][7:0] csc;
      logic [1:0][7:0] csc_en;
      logic [1:0] present;
      logic [1:0] vcc;
      logic [1:0] vpp;
      logic strobe_prev;
      logic ack;
      logic [31:0] rdata;
   } csp_dev_st_t;

   csp_dev_st_t s_q;
   csp_dev_st_t s_d;
   logic wen;
   logic [7:0] widx;
   logic [7:0] wbyte;
   logic [7:0] loc;
   logic [1:0] pres;
   logic [1:0] ins;
   logic [1:0] rem;
   logic [1:0] push_valid;
   logic [1:0] push_ready;
   logic [1:0] head_set;
   logic [1:0][7:0] t_setup;
   logic [1:0][7:0] t_cmd;
   logic [1:0][7:0] t_rec;
   logic [DW:0] push_data;
   logic [3:0] vs_lvl;
   integer k;

   // read decode of the register selected by an index
   function automatic logic [7:0] rd_reg(input csp_dev_st_t s, input logic [7:0] ix,
                                         input logic [3:0] vs);
      logic [7:0] lx;
      logic sk;
      lx = ix & ~(8'h01 << csp_pkg::SOCK_BIT);
      sk = ix[csp_pkg::SOCK_BIT];
      rd_reg = 8'h00;
      if (ix == csp_pkg::IDX_EXT_INDEX)
         rd_reg = s.ext_idx;
      else if (ix == csp_pkg::IDX_EXT_DATA)
      begin
         case (s.ext_idx)
            csp_pkg::EXT_CTL1: rd_reg = s.ext1;
            csp_pkg::EXT_CTL2: rd_reg = s.ext2;
            csp_pkg::EXT_PORT:
               rd_reg = s.ext2[csp_pkg::EXT2_RD_EN] ? s.gp_rd : {4'h0, vs};
            default: rd_reg = 8'h00;
         endcase
      end
      else if (ix == csp_pkg::IDX_TSEL)
         rd_reg = s.tsel;
      else if (ix >= csp_pkg::IDX_TIM0 && ix < csp_pkg::IDX_TIM0 + 8'h06)
         rd_reg = s.tim[3'(ix - csp_pkg::IDX_TIM0)];
      else if (lx == csp_pkg::IDX_PWR)
         rd_reg = s.pwr[sk];
      else if (lx == csp_pkg::IDX_CSC)
         rd_reg = s.csc[sk];
      else if (lx == csp_pkg::IDX_CSC_EN)
         rd_reg = s.csc_en[sk];
   endfunction : rd_reg

   assign vs_lvl = {i_voltage_sense_strobe_two[1], i_voltage_sense_strobe_one[1],
                    i_voltage_sense_strobe_two[0], i_voltage_sense_strobe_one[0]};

   always_comb
   begin
      s_d = s_q;
      s_d.ack = 1'b0;
      wen = 1'b0;
      widx = s_q.idx;
      wbyte = link.wdata[7:0];
      push_valid = 2'b00;
      push_data = {s_q.tsel[link.win ? csp_pkg::TSEL_IO : csp_pkg::TSEL_MEM],
                   link.wdata};
      // host request, answered with a 32-bit word one cycle later for registers, one cycle after the fifo push for card writes
      if (link.req && !s_q.ack)
      begin
         if (link.space)
         begin
            push_valid[link.sock] = 1'b1;
            s_d.ack = push_ready[link.sock];
         end
         else
         begin
            s_d.ack = 1'b1;
            if (link.wr)
            begin
               if (!link.addr)
               begin
                  s_d.idx = link.wdata[7:0];
                  wen = link.be[1];
                  widx = link.wdata[7:0];
                  wbyte = link.wdata[15:8];
               end
               else
                  wen = 1'b1;
            end
            else if (link.addr)
               s_d.rdata = {24'h000000, rd_reg(s_q, s_q.idx, vs_lvl)};
            else
               s_d.rdata = {16'h0000, rd_reg(s_q, s_q.idx, vs_lvl), s_q.idx};
         end
      end
      loc = widx & ~(8'h01 << csp_pkg::SOCK_BIT);
      if (wen)
      begin
         if (widx == csp_pkg::IDX_EXT_INDEX)
            s_d.ext_idx = wbyte;
         else if (widx == csp_pkg::IDX_EXT_DATA)
         begin
            case (s_q.ext_idx)
               csp_pkg::EXT_CTL1: s_d.ext1 = wbyte;
               csp_pkg::EXT_CTL2: s_d.ext2 = wbyte;
               csp_pkg::EXT_PORT: s_d.gp_wr = wbyte;
               default: s_d.ext1 = s_q.ext1;
            endcase
         end
         else if (widx == csp_pkg::IDX_TSEL)
            s_d.tsel = wbyte;
         else if (widx >= csp_pkg::IDX_TIM0 && widx < csp_pkg::IDX_TIM0 + 8'h06)
            s_d.tim[3'(widx - csp_pkg::IDX_TIM0)] = wbyte;
         else if (loc == csp_pkg::IDX_PWR)
            s_d.pwr[widx[csp_pkg::SOCK_BIT]] = wbyte;
         else if (loc == csp_pkg::IDX_CSC) // write one to clear
            s_d.csc[widx[csp_pkg::SOCK_BIT]] = s_q.csc[widx[csp_pkg::SOCK_BIT]] & ~wbyte;
         else if (loc == csp_pkg::IDX_CSC_EN)
            s_d.csc_en[widx[csp_pkg::SOCK_BIT]] = wbyte;
      end
      // read port latched on strobe rising edge
      s_d.strobe_prev = i_voltage_sense_strobe_one[0];
      if (s_q.ext2[csp_pkg::EXT2_RD_EN] && i_voltage_sense_strobe_one[0]
          && !s_q.strobe_prev)
         s_d.gp_rd = i_gp_rd_data;
      // socket power and events, after the writes so a set beats a clear
      for (k = 0; k < 2; k = k + 1)
      begin
         pres[k] = !i_card_detect_first_n[k] && !i_card_detect_second_n[k];
         ins[k] = pres[k] && !s_q.present[k];
         rem[k] = !pres[k] && s_q.present[k];
         s_d.present[k] = pres[k];
         if (!s_q.pwr[k][csp_pkg::PWR_AUTO_B])
         begin
            // manual: software powers only a present card
            s_d.vcc[k] = pres[k] && s_q.pwr[k][csp_pkg::PWR_VCC];
            s_d.vpp[k] = s_d.vcc[k] && (s_q.pwr[k][csp_pkg::PWR_VPP_LO +: 2] != 2'b00);
         end
         else if (ins[k] && s_q.pwr[k][csp_pkg::PWR_AUTO_A])
         begin
            s_d.vcc[k] = 1'b1;
            s_d.vpp[k] = (s_q.pwr[k][csp_pkg::PWR_VPP_LO +: 2] != 2'b00);
         end
         if (!pres[k] && s_q.ext1[csp_pkg::EXT1_AUTO_OFF])
         begin
            s_d.vcc[k] = 1'b0;
            s_d.vpp[k] = 1'b0;
         end
         if ((ins[k] || rem[k]) && s_q.csc_en[k][csp_pkg::CSC_DET])
            s_d.csc[k][csp_pkg::CSC_DET] = 1'b1;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
      begin
         s_q <= '0;
         s_q.ext1 <= csp_pkg::RST_EXT1;
         s_q.tim <= {6{csp_pkg::RST_TIM}};
      end
      else
         s_q <= s_d;
   end

   // two independent socket fifos
   for (genvar g = 0; g < 2; g++)
   begin : g_sock
      assign t_setup[g] = s_q.tim[head_set[g] ? 3 : 0];
      assign t_cmd[g] = s_q.tim[head_set[g] ? 4 : 1];
      assign t_rec[g] = s_q.tim[head_set[g] ? 5 : 2];
      csp_wfifo #(.W(DW), .DEPTH(DEPTH)) csp_wfifo_inst (
         .i_mclk(i_mclk),
         .i_rst_n(i_rst_n),
         .i_push_valid(push_valid[g]),
         .i_push_data(push_data),
         .o_push_ready(push_ready[g]),
         .o_head_set(head_set[g]),
         .i_setup(t_setup[g]),
         .i_cmd(t_cmd[g]),
         .i_rec(t_rec[g]),
         .o_empty(o_fifo_empty[g]),
         .o_card_cmd(o_card_cmd[g]),
         .o_card_data(o_card_data[g])
      );
   end

   assign link.ready = s_q.ack;
   assign link.rdata = s_q.rdata;
   assign o_vcc_en = s_q.vcc;
   assign o_vpp_en = s_q.vpp;
   assign o_mgmt_irq = |(s_q.csc[0] | s_q.csc[1]);
   assign o_gp_wr_data = s_q.gp_wr;
   assign o_gp_wr_oe = s_q.ext2[csp_pkg::EXT2_WR_EN];
endmodule : csp_socket_dev

// file: csp_socket_host.sv
// host end: apb command registers driving the link
`timescale 1ns/1ps
module csp_socket_host (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // device link
   csp_link_if.hst link
);
   typedef struct packed {
      logic [31:0] wdata;
      logic [7:0] ctrl;
      logic busy;
      logic [31:0] rdata;
   } csp_host_st_t;

   csp_host_st_t s_q;
   csp_host_st_t s_d;
   logic acc;
   logic hit;

   always_comb
   begin
      s_d = s_q;
      acc = i_psel && i_penable;
      hit = (i_paddr == csp_pkg::A_CMD) || (i_paddr == csp_pkg::A_CTRL)
            || (i_paddr == csp_pkg::A_STAT) || (i_paddr == csp_pkg::A_RDATA);
      // no new command while one is in flight
      if (acc && i_pwrite && !s_q.busy)
      begin
         if (i_paddr == csp_pkg::A_CMD)
            s_d.wdata = i_pwdata;
         if (i_paddr == csp_pkg::A_CTRL)
         begin
            s_d.ctrl = i_pwdata[7:0];
            s_d.busy = i_pwdata[csp_pkg::C_GO];
         end
      end
      if (s_q.busy && link.ready)
      begin
         s_d.busy = 1'b0;
         s_d.rdata = link.rdata;
      end
      case (i_paddr)
         csp_pkg::A_CMD: o_prdata = s_q.wdata;
         csp_pkg::A_CTRL: o_prdata = {24'h000000, s_q.ctrl};
         csp_pkg::A_STAT: o_prdata = {31'h0, s_q.busy};
         csp_pkg::A_RDATA: o_prdata = s_q.rdata;
         default: o_prdata = 32'h00000000;
      endcase
      o_pready = 1'b1;
      o_pslverr = acc && !hit;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign link.req = s_q.busy;
   assign link.wr = s_q.ctrl[csp_pkg::C_WR];
   assign link.addr = s_q.ctrl[csp_pkg::C_ADDR];
   assign link.space = s_q.ctrl[csp_pkg::C_SPACE];
   assign link.sock = s_q.ctrl[csp_pkg::C_SOCK];
   assign link.win = s_q.ctrl[csp_pkg::C_WIN];
   assign link.be = s_q.ctrl[csp_pkg::C_BE +: 2];
   assign link.wdata = s_q.wdata;
endmodule : csp_socket_host

// file: csp_link_sva.sv
// link checker for the host and device ends
`timescale 1ns/1ps
module csp_link_sva (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // link signals
   input wire logic i_req,
   input wire logic i_wr,
   input wire logic i_addr,
   input wire logic i_space,
   input wire logic i_sock,
   input wire logic i_win,
   input wire logic [1:0] i_be,
   input wire logic [31:0] i_wdata,
   input wire logic i_ready,
   input wire logic [31:0] i_rdata
);
   default clocking dc @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);
   sequence reg_start_s;
      $rose(i_req) && !i_space;
   endsequence
   sequence card_start_s;
      $rose(i_req) && i_space;
   endsequence
   sequence reg_read_s;
      i_ready && !i_wr && !i_space;
   endsequence
   ready_one_cycle_a: assert property (i_ready |=> !i_ready)
      else $error("ready held longer than one cycle");
   ready_needs_req_a: assert property (i_ready |-> i_req)
      else $error("ready without a pending request");
   req_held_a: assert property (i_req && !i_ready |=> i_req &&
      $stable({i_wr, i_addr, i_space, i_sock, i_win, i_be, i_wdata}))
      else $error("request changed before its answer");
   req_released_a: assert property (i_ready |=> !i_req)
      else $error("request kept after its answer");
   reg_answer_a: assert property (reg_start_s |=> i_ready)
      else $error("register access not answered in one cycle");
   card_answer_a: assert property (card_start_s |-> ##[1:200] i_ready)
      else $error("card write never answered");
   rdata_kept_a: assert property ($changed(i_rdata) |-> i_ready)
      else $error("read data changed without an answer");
   data_port_width_a: assert property (reg_read_s ##0 i_addr |->
      i_rdata[31:8] == 24'h0)
      else $error("data port read not zero extended");
   index_port_width_a: assert property (reg_read_s ##0 !i_addr |->
      i_rdata[31:16] == 16'h0)
      else $error("index port read not zero extended");
endmodule : csp_link_sva

// file: card_socket_power_and_index_access_test.sv
// self-checking bench joining the host and device ends
`timescale 1ns/1ps
module card_socket_power_and_index_access_test;
   logic i_mclk, i_rst_n, psel, penable, pwrite, pready, pslverr, irq, gp_oe, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] cd1_n, cd2_n, vs1, vs2, vcc, vpp, card_cmd, fifo_empty;
   logic [1:0][31:0] card_data;
   logic [7:0] gp_rd, gp_wr;
   int fails, n_tests, p;
   csp_link_if csp_link_if_inst ();
   csp_socket_host csp_socket_host_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .link(csp_link_if_inst.hst));
   csp_socket_dev csp_socket_dev_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .link(csp_link_if_inst.dev), .i_card_detect_first_n(cd1_n), .i_card_detect_second_n(cd2_n),
      .i_voltage_sense_strobe_one(vs1), .i_voltage_sense_strobe_two(vs2), .o_vcc_en(vcc),
      .o_vpp_en(vpp), .o_card_cmd(card_cmd), .o_card_data(card_data), .o_fifo_empty(fifo_empty),
      .o_mgmt_irq(irq), .i_gp_rd_data(gp_rd), .o_gp_wr_data(gp_wr), .o_gp_wr_oe(gp_oe));
   csp_link_sva csp_link_sva_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .i_req(csp_link_if_inst.req), .i_wr(csp_link_if_inst.wr),
      .i_addr(csp_link_if_inst.addr), .i_space(csp_link_if_inst.space),
      .i_sock(csp_link_if_inst.sock), .i_win(csp_link_if_inst.win),
      .i_be(csp_link_if_inst.be), .i_wdata(csp_link_if_inst.wdata),
      .i_ready(csp_link_if_inst.ready), .i_rdata(csp_link_if_inst.rdata));
   initial
   begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   task automatic timeout_hit();
      fails++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      final_report();
   endtask : timeout_hit
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask : wait_cyc
   // one apb transfer, entered right after a rising edge, idle cycle after it
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_mclk);
      penable <= 1'b1;
      for (k = 0; k < 50; k++)
      begin
         @(posedge i_mclk);
         if (pready === 1'b1) break;
      end
      if (k == 50) timeout_hit();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_mclk);
   endtask : apb
   // command word, then go, then poll busy; polls tells how long the link stalled
   task automatic link_op(input logic [7:0] ctl, input logic [31:0] d, output int polls);
      apb(1'b1, csp_pkg::A_CMD, d);
      apb(1'b1, csp_pkg::A_CTRL, {24'h0, ctl | 8'h01});
      polls = 0;
      do
      begin
         apb(1'b0, csp_pkg::A_STAT, 32'h0);
         polls++;
         if (polls > 200) timeout_hit();
      end while (rd[0] !== 1'b0);
   endtask : link_op
   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
      link_op(8'hc2, {16'h0, d, idx}, p);
   endtask : reg_wr
   task automatic reg_rd(input logic [7:0] idx);
      link_op(8'h42, {24'h0, idx}, p);
      link_op(8'h04, 32'h0, p);
      apb(1'b0, csp_pkg::A_RDATA, 32'h0);
   endtask : reg_rd
   task automatic ext_wr(input logic [7:0] e, input logic [7:0] d);
      reg_wr(csp_pkg::IDX_EXT_INDEX, e);
      reg_wr(csp_pkg::IDX_EXT_DATA, d);
   endtask : ext_wr
   task automatic ext_rd(input logic [7:0] e);
      reg_wr(csp_pkg::IDX_EXT_INDEX, e);
      reg_rd(csp_pkg::IDX_EXT_DATA);
   endtask : ext_rd
   task automatic do_reset();
      i_rst_n <= 1'b0;
      wait_cyc(12);
      i_rst_n <= 1'b1;
      wait_cyc(1);
   endtask : do_reset
   task automatic t_reset();
      chk({25'h0, vcc, vpp, irq, fifo_empty}, 32'h3);
      ext_rd(csp_pkg::EXT_CTL1);
      chk(rd, {24'h0, csp_pkg::RST_EXT1});
      reg_rd(csp_pkg::IDX_TIM0);
      chk(rd, {24'h0, csp_pkg::RST_TIM});
      reg_wr(csp_pkg::IDX_PWR, 8'h80);
      link_op(8'h00, 32'h0, p);
      apb(1'b0, csp_pkg::A_RDATA, 32'h0);
      chk(rd, 32'h8002);
      chk({30'h0, vcc}, 32'h0);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      // manual mode: software powers a present card itself
      cd1_n[0] <= 1'b0;
      cd2_n[0] <= 1'b0;
      wait_cyc(4);
      chk({30'h0, vcc[0], vpp[0]}, 32'h2);
      cd1_n[0] <= 1'b1;
      cd2_n[0] <= 1'b1;
      wait_cyc(4);
      chk({30'h0, vcc[0], vpp[0]}, 32'h0);
      reg_wr(csp_pkg::IDX_PWR, 8'h00);
      $display("test reset values done");
   endtask : t_reset
   task automatic t_power();
      reg_wr(csp_pkg::IDX_PWR, 8'h31);
      reg_wr(csp_pkg::IDX_CSC_EN, 8'h08);
      cd1_n[0] <= 1'b0;
      wait_cyc(4);
      chk({29'h0, vcc[0], vpp[0], irq}, 32'h0);
      cd2_n[0] <= 1'b0;
      wait_cyc(4);
      chk({29'h0, vcc[0], vpp[0], irq}, 32'h7);
      reg_wr(csp_pkg::IDX_CSC, 8'h08);
      chk({31'h0, irq}, 32'h0);
      cd1_n[0] <= 1'b1;
      cd2_n[0] <= 1'b1;
      wait_cyc(4);
      chk({29'h0, vcc[0], vpp[0], irq}, 32'h1);
      reg_wr(csp_pkg::IDX_CSC, 8'h08);
      $display("test automatic power done");
   endtask : t_power
   task automatic t_no_auto_off();
      ext_wr(csp_pkg::EXT_CTL1, 8'h00);
      reg_wr(csp_pkg::IDX_CSC_EN, 8'h00);
      cd1_n[0] <= 1'b0;
      cd2_n[0] <= 1'b0;
      wait_cyc(4);
      chk({30'h0, vcc[0], irq}, 32'h2);
      cd1_n[0] <= 1'b1;
      cd2_n[0] <= 1'b1;
      wait_cyc(4);
      chk({31'h0, vcc[0]}, 32'h1);
      ext_wr(csp_pkg::EXT_CTL1, csp_pkg::RST_EXT1);
      chk({31'h0, vcc[0]}, 32'h0);
      $display("test power kept on removal done");
   endtask : t_no_auto_off
   // waits for one command phase, checks its data and its length in cycles
   task automatic card_cycle(input logic [31:0] d, input int len);
      int k, n;
      for (k = 0; k < 400 && card_cmd[0] !== 1'b1; k++) @(posedge i_mclk);
      if (k == 400) timeout_hit();
      chk(card_data[0], d);
      for (n = 0; n < 400 && card_cmd[0] === 1'b1; n++) @(posedge i_mclk);
      chk(n, len);
   endtask : card_cycle
   task automatic t_fifo();
      int i, j, q;
      int wp[5];
      reg_wr(csp_pkg::IDX_TIM0 + 8'h01, 8'h7f);
      fork
         for (i = 0; i < 5; i++)
         begin
            link_op(8'hca, 32'ha5a50000 + i, q);
            wp[i] = q;
         end
         for (j = 0; j < 5; j++)
         begin
            card_cycle(32'ha5a50000 + j, 128);
         end
      join
      for (i = 0; i < 4; i++) chk({31'h0, wp[i] <= 3}, 32'h1);
      chk({31'h0, wp[4] > 3}, 32'h1);
      wait_cyc(10);
      chk({30'h0, fifo_empty}, 32'h3);
      reg_wr(csp_pkg::IDX_TSEL, 8'h01);
      reg_wr(csp_pkg::IDX_TIM1 + 8'h01, 8'h02);
      fork
         link_op(8'hca, 32'h0bad0f1f, q);
         card_cycle(32'h0bad0f1f, 3);
      join
      // io window still selects set 0
      fork
         link_op(8'hea, 32'h0bad0f2f, q);
         card_cycle(32'h0bad0f2f, 128);
      join
      link_op(8'hda, 32'h5a5a0001, q);
      wait_cyc(20);
      chk(card_data[1], 32'h5a5a0001);
      chk({28'h0, card_cmd, fifo_empty}, 32'h3);
      $display("test write fifo and timing sets done");
   endtask : t_fifo
   task automatic t_port();
      vs1 <= 2'b01;
      vs2 <= 2'b10;
      ext_rd(csp_pkg::EXT_PORT);
      chk(rd & 32'hf, 32'h9);
      ext_wr(csp_pkg::EXT_CTL2, 8'h10);
      ext_wr(csp_pkg::EXT_PORT, 8'h5a);
      chk({23'h0, gp_oe, gp_wr}, 32'h15a);
      ext_wr(csp_pkg::EXT_CTL2, 8'h08);
      vs1[0] <= 1'b0;
      gp_rd <= 8'hc3;
      wait_cyc(3);
      vs1[0] <= 1'b1;
      wait_cyc(3);
      gp_rd <= 8'h3c;
      ext_rd(csp_pkg::EXT_PORT);
      chk({gp_oe, rd[30:0]}, 32'hc3);
      do_reset();
      ext_rd(csp_pkg::EXT_CTL2);
      chk({gp_oe, rd[30:0]}, 32'h0);
      chk({24'h0, gp_wr}, 32'h0);
      $display("test general purpose ports done");
   endtask : t_port
   initial
   begin
      {i_rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {cd1_n, cd2_n, vs1, vs2, gp_rd} = {4'hf, 12'h0};
      {fails, n_tests} = '0;
      do_reset();
      t_reset();
      t_power();
      t_no_auto_off();
      t_fifo();
      t_port();
      final_report();
   end
endmodule : card_socket_power_and_index_access_test
